// ---- src/drc_pkg.sv ----
package drc_pkg;
    // ------------------------------------------------------------
    // Direction permission codes
    // ------------------------------------------------------------
    localparam logic [1:0] DIR_BOTH = 2'h0;
    localparam logic [1:0] DIR_NO_REV = 2'h1;
    localparam logic [1:0] DIR_NO_FWD = 2'h2;
    // ------------------------------------------------------------
    // Terminal scheme codes
    // ------------------------------------------------------------
    localparam logic [1:0] SCH_FWD_REV = 2'h0;
    localparam logic [1:0] SCH_RUN_DIR = 2'h1;
    localparam logic [1:0] SCH_3WIRE = 2'h2;
    // ------------------------------------------------------------
    // Command source codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_KEYPAD = 3'h0;
    localparam logic [2:0] SRC_TERM_STOP_ON = 3'h1;
    localparam logic [2:0] SRC_TERM_STOP_OFF = 3'h2;
    localparam logic [2:0] SRC_SER_STOP_ON = 3'h3;
    localparam logic [2:0] SRC_SER_STOP_OFF = 3'h4;
    // ------------------------------------------------------------
    // Lockout bit positions and loss reactions
    // ------------------------------------------------------------
    localparam int LOCK_PWR_BIT = 0;
    localparam int LOCK_FOLLOW_BIT = 1;
    localparam logic [1:0] LOSS_DECEL = 2'h0;
    localparam logic [1:0] LOSS_COAST = 2'h1;
    localparam logic [1:0] LOSS_HOLD = 2'h2;
    // Motion states
    typedef enum logic [2:0] {
        DRC_STOP = 3'b001,
        DRC_FWD = 3'b010,
        DRC_REV = 3'b100
    } drc_run_e;
endpackage

// ---- src/drc_run_command.sv ----
`timescale 1ns/10ps
// How it works
// - Permission 00 both, 01 no reverse, 02 no forward
// - Scheme 01: first input run, second selects direction
// - Scheme 02: direction input, run pulse, stop opens
// - Lockout governs power-up start and source change
// - Lockout 0 or 2 runs at power-up
// - Lockout 1 or 3 waits release then reassert
// - Power-up lockout only for terminal source
// - Source change checked only entering terminals, differing
// - Lockout 0 or 1 keeps state after change
// - Lockout 2 or 3 follows terminals after change
// - Loss setting 00 ramps down to zero
// - Loss setting 01 coasts, shows external fault
// - Loss setting 02 holds last frequency
// - Loss settings 00, 02 raise loss warning
// - Warning clears on return, or on mode key unless loss persists under 00, 02
// - Source codes: keypad, terminals, serial; stop-key enable
module drc_run_command (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic forward_run_input_i,
    input wire logic reverse_run_input_i,
    input wire logic stop_contact_i,
    input wire logic loop_lost_i,
    input wire logic [1:0] direction_permission_setting_i,
    input wire logic [1:0] terminal_scheme_setting_i,
    input wire logic [1:0] start_lockout_setting_i,
    input wire logic [1:0] reference_loss_setting_i,
    input wire logic [2:0] command_source_i,
    input wire logic other_run_i,
    input wire logic other_fwd_i,
    input wire logic mode_key_i,
    output logic run_o,
    output logic fwd_o,
    output logic rev_o,
    output logic ramp_to_zero_o,
    output logic coast_stop_o,
    output logic hold_freq_o,
    output logic external_fault_indication_o,
    output logic analog_loss_warning_o,
    output logic stop_key_enable_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else if (en_i) begin
            sync1_reg <= {loop_lost_i, stop_contact_i, reverse_run_input_i, forward_run_input_i};
            sync2_reg <= sync1_reg;
        end
    end
    wire fwd_in = sync2_reg[0];
    wire rev_in = sync2_reg[1];
    wire stop_ok = sync2_reg[2];
    wire lost = sync2_reg[3];

    // ------------------------------------------------------------
    // Power-up window, opens once the synchronisers hold pin values
    // ------------------------------------------------------------
    logic [1:0] fill_reg;
    logic pwr_arm_reg;
    wire fill_done = fill_reg[1];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fill_reg <= 2'h0;
            pwr_arm_reg <= 1'b1;
        end else if (en_i) begin
            fill_reg <= {fill_reg[0], 1'b1};
            pwr_arm_reg <= pwr_arm_reg && !fill_done;
        end
    end

    // ------------------------------------------------------------
    // Terminal decode
    // ------------------------------------------------------------
    logic latch_reg;
    logic latch_next;
    wire is_2a = terminal_scheme_setting_i == drc_pkg::SCH_FWD_REV;
    wire is_2b = terminal_scheme_setting_i == drc_pkg::SCH_RUN_DIR;
    wire is_3w = terminal_scheme_setting_i == drc_pkg::SCH_3WIRE;
    // Run latch set by momentary run contact, cleared by open stop contact
    assign latch_next = is_3w && stop_ok && (latch_reg || fwd_in);
    wire term_fwd_2a = fwd_in && !rev_in;
    wire term_rev_2a = rev_in && !fwd_in;
    wire term_run = is_2a ? (fwd_in ^ rev_in) : is_2b ? fwd_in : latch_reg;
    wire term_dir_rev = is_2a ? term_rev_2a : rev_in;
    wire raw_level = is_2a ? (fwd_in || rev_in) : is_2b ? fwd_in : latch_next;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    wire src_term = command_source_i == drc_pkg::SRC_TERM_STOP_ON ||
                    command_source_i == drc_pkg::SRC_TERM_STOP_OFF;
    assign stop_key_enable_o = command_source_i == drc_pkg::SRC_KEYPAD ||
                               command_source_i == drc_pkg::SRC_TERM_STOP_ON ||
                               command_source_i == drc_pkg::SRC_SER_STOP_ON;
    logic src_term_reg;
    logic blocked_reg;
    logic hold_reg;
    wire lock_pwr = start_lockout_setting_i[drc_pkg::LOCK_PWR_BIT];
    wire lock_follow = start_lockout_setting_i[drc_pkg::LOCK_FOLLOW_BIT];
    wire entering = src_term && !src_term_reg;
    // State held across a change when terminals differ from the drive
    wire differ = (term_run != run_o) || (term_run && (term_dir_rev == fwd_o));
    wire start_hold = entering && !lock_follow && differ;
    // Power-up block on an asserted terminal command
    wire start_block = pwr_arm_reg && fill_done && src_term && lock_pwr && raw_level;
    wire release_hold = hold_reg && !differ;

    // ------------------------------------------------------------
    // Source-selected request with permission
    // ------------------------------------------------------------
    wire req_run = src_term ? (term_run && !blocked_reg && !start_block) : other_run_i;
    wire req_rev = src_term ? term_dir_rev : !other_fwd_i;
    // Hold applies from the very cycle the source changes
    wire hold_now = hold_reg || start_hold;
    wire sel_run = hold_now ? run_o : req_run;
    wire sel_rev = hold_now ? rev_o : req_rev;
    wire perm_ok = direction_permission_setting_i == drc_pkg::DIR_BOTH ||
                   (direction_permission_setting_i == drc_pkg::DIR_NO_REV && !sel_rev) ||
                   (direction_permission_setting_i == drc_pkg::DIR_NO_FWD && sel_rev);
    function automatic logic loss_is(input logic lost_f, input logic [1:0] set_f, input logic [1:0] code_f);
        loss_is = lost_f && set_f == code_f;
    endfunction
    wire coast_now = loss_is(lost, reference_loss_setting_i, drc_pkg::LOSS_COAST);
    wire run_next = sel_run && perm_ok && !coast_now && !(coast_stop_o);

    drc_pkg::drc_run_e state_reg;
    drc_pkg::drc_run_e state_next;
    assign state_next = !run_next ? drc_pkg::DRC_STOP : sel_rev ? drc_pkg::DRC_REV : drc_pkg::DRC_FWD;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= drc_pkg::DRC_STOP;
            latch_reg <= 1'b0;
            src_term_reg <= 1'b0;
            blocked_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (en_i) begin
            state_reg <= state_next;
            latch_reg <= latch_next;
            src_term_reg <= src_term;
            // Power-up block lasts until the command is released
            if (start_block) begin
                blocked_reg <= 1'b1;
            end else if (!raw_level) begin
                blocked_reg <= 1'b0;
            end
            if (start_hold) begin
                hold_reg <= 1'b1;
            end else if (release_hold || !src_term) begin
                hold_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        run_o = 1'b0;
        fwd_o = 1'b0;
        rev_o = 1'b0;
        unique case (state_reg)
            drc_pkg::DRC_STOP: begin
                run_o = 1'b0;
            end
            drc_pkg::DRC_FWD: begin
                run_o = 1'b1;
                fwd_o = 1'b1;
            end
            drc_pkg::DRC_REV: begin
                run_o = 1'b1;
                rev_o = 1'b1;
            end
            default: begin
                run_o = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Reference loss reaction
    // ------------------------------------------------------------
    logic ramp_reg;
    logic coast_reg;
    logic hold_f_reg;
    logic fault_reg;
    logic warn_reg;
    wire warn_set = lost && (reference_loss_setting_i == drc_pkg::LOSS_DECEL ||
                             reference_loss_setting_i == drc_pkg::LOSS_HOLD);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ramp_reg <= 1'b0;
            coast_reg <= 1'b0;
            hold_f_reg <= 1'b0;
            fault_reg <= 1'b0;
            warn_reg <= 1'b0;
        end else if (en_i) begin
            ramp_reg <= loss_is(lost, reference_loss_setting_i, drc_pkg::LOSS_DECEL);
            coast_reg <= coast_now;
            hold_f_reg <= loss_is(lost, reference_loss_setting_i, drc_pkg::LOSS_HOLD);
            if (coast_now) begin
                fault_reg <= 1'b1;
            end else if (mode_key_i) begin
                fault_reg <= 1'b0;
            end
            // Set wins over the clears
            if (warn_set) begin
                warn_reg <= 1'b1;
            end else if (!lost || mode_key_i) begin
                warn_reg <= 1'b0;
            end
        end
    end
    assign ramp_to_zero_o = ramp_reg;
    assign coast_stop_o = coast_reg;
    assign hold_freq_o = hold_f_reg;
    assign external_fault_indication_o = fault_reg;
    assign analog_loss_warning_o = warn_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    no_rev_perm_a: assert property ($past(direction_permission_setting_i) == drc_pkg::DIR_NO_REV && $past(en_i)
        |-> !rev_o) else $error("reverse while blocked");
    no_fwd_perm_a: assert property ($past(direction_permission_setting_i) == drc_pkg::DIR_NO_FWD && $past(en_i)
        |-> !fwd_o) else $error("forward while blocked");
    three_latch_a: assert property (en_i && is_3w && !stop_ok |=> !latch_reg) else $error("latch not cleared");
    coast_out_a: assert property (en_i && coast_now |=> coast_stop_o && external_fault_indication_o && !run_o)
        else $error("coast reaction missing");
    ramp_out_a: assert property (en_i && lost && reference_loss_setting_i == drc_pkg::LOSS_DECEL
        |=> ramp_to_zero_o && analog_loss_warning_o) else $error("ramp reaction missing");
    hold_out_a: assert property (en_i && lost && reference_loss_setting_i == drc_pkg::LOSS_HOLD
        |=> hold_freq_o && analog_loss_warning_o) else $error("hold reaction missing");
    warn_clear_a: assert property (en_i && !warn_set && (!lost || mode_key_i) |=> !analog_loss_warning_o)
        else $error("warning not cleared");
    pwr_block_a: assert property (en_i && start_block |=> !run_o) else $error("started under lockout");
    stop_key_a: assert property (command_source_i == drc_pkg::SRC_TERM_STOP_OFF |-> !stop_key_enable_o)
        else $error("stop key not disabled");
    key_enable_a: assert property (command_source_i == drc_pkg::SRC_TERM_STOP_ON |-> stop_key_enable_o)
        else $error("stop key not enabled");
    serial_key_a: assert property (command_source_i == drc_pkg::SRC_SER_STOP_OFF |-> !stop_key_enable_o)
        else $error("serial stop key not disabled");
    en_freeze_a: assert property (!en_i |=> $stable(state_reg) && $stable(latch_reg))
        else $error("state moved while frozen");
    sync_chain_a: assert property (en_i |=> sync2_reg == $past(sync1_reg))
        else $error("synchroniser skipped a stage");
    one_dir_a: assert property (!(fwd_o && rev_o)) else $error("both directions at once");
    run_dir_link_a: assert property (run_o == (fwd_o || rev_o)) else $error("run without direction");
    two_wire_both_a: assert property (en_i && is_2a && fwd_in && rev_in && src_term && !hold_now
        |=> !run_o) else $error("ran with both contacts closed");
    run_dir_sel_a: assert property (en_i && is_2b && src_term && !hold_now && fwd_in && rev_in
        && !blocked_reg && !start_block && direction_permission_setting_i == drc_pkg::DIR_BOTH
        && !coast_now && !coast_stop_o |=> rev_o) else $error("direction input ignored");
    latch_set_a: assert property (en_i && is_3w && stop_ok && fwd_in |=> latch_reg)
        else $error("run pulse not latched");
    latch_idle_a: assert property (en_i && !is_3w |=> !latch_reg) else $error("latch set outside three-wire");
    block_keep_a: assert property (en_i && blocked_reg && raw_level |=> blocked_reg)
        else $error("lockout dropped early");
    pwr_window_a: assert property (en_i && fill_done |=> !pwr_arm_reg)
        else $error("power-up window stays open");
    keep_change_a: assert property (en_i && start_hold && run_o && perm_ok && !coast_now && !coast_stop_o
        |=> run_o) else $error("run dropped on source change");
    follow_change_a: assert property (en_i && entering && lock_follow && !term_run |=> !run_o)
        else $error("terminals not followed");
    hold_keep_a: assert property (en_i && hold_reg && !release_hold && src_term |=> hold_reg)
        else $error("hold released early");
    fault_sticky_a: assert property (en_i && fault_reg && !mode_key_i |=> external_fault_indication_o)
        else $error("fault cleared without key");
    fault_clear_a: assert property (en_i && !coast_now && mode_key_i |=> !external_fault_indication_o)
        else $error("fault not cleared by key");
    no_loss_out_a: assert property (en_i && !lost |=> !ramp_to_zero_o && !coast_stop_o && !hold_freq_o)
        else $error("loss reaction without loss");
    coast_no_warn_a: assert property (en_i && coast_now && !warn_reg |=> !analog_loss_warning_o)
        else $error("warning raised on coast");
    run_fwd_c: cover property (fwd_o ##1 !run_o);
    run_rev_c: cover property (rev_o);
    coast_c: cover property (coast_stop_o);
    hold_c: cover property (hold_reg ##1 !hold_reg);
    block_c: cover property (blocked_reg);
endmodule // drc_run_command

// ---- bench/drc_contact_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Switch contacts to digital common, seen from the drive pins
// ------------------------------------------------------------
module drc_contact_model (
    input wire logic clk_i,
    input wire logic fwd_req_i,
    input wire logic rev_req_i,
    input wire logic stop_req_i,
    input wire logic lost_req_i,
    output logic forward_run_input_o,
    output logic reverse_run_input_o,
    output logic stop_contact_o,
    output logic loop_lost_o
);
    initial begin
        forward_run_input_o = 1'b0;
        reverse_run_input_o = 1'b0;
        stop_contact_o = 1'b1;
        loop_lost_o = 1'b0;
    end
    // Contacts move on the falling edge, away from the sampling edge
    always @(negedge clk_i) begin
        forward_run_input_o <= fwd_req_i;
        reverse_run_input_o <= rev_req_i;
        stop_contact_o <= stop_req_i;
        loop_lost_o <= lost_req_i;
    end
endmodule // drc_contact_model

// ---- bench/drc_run_command_tb_top.sv ----
`timescale 1ns/10ps
module drc_run_command_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic en_i = 1'b1;
    logic fwd_req = 1'b0, rev_req = 1'b0, stop_req = 1'b1, lost_req = 1'b0;
    logic fwd_pin, rev_pin, stop_pin, lost_pin;
    logic [1:0] dir_set = 2'h0, scheme_set = 2'h0, lock_set = 2'h1, loss_set = 2'h0;
    logic [2:0] source = 3'h1;
    logic other_run = 1'b0, other_fwd = 1'b1, mode_key = 1'b0;
    logic run, forward_run_input, reverse_run_input, ramp, coast, hold, fault, warn, stop_key;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    always #2 clk_i = ~clk_i;
    drc_contact_model model_u (.clk_i(clk_i), .fwd_req_i(fwd_req), .rev_req_i(rev_req), .stop_req_i(stop_req),
        .lost_req_i(lost_req), .forward_run_input_o(fwd_pin), .reverse_run_input_o(rev_pin),
        .stop_contact_o(stop_pin), .loop_lost_o(lost_pin));
    drc_run_command dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .forward_run_input_i(fwd_pin),
        .reverse_run_input_i(rev_pin), .stop_contact_i(stop_pin), .loop_lost_i(lost_pin),
        .direction_permission_setting_i(dir_set), .terminal_scheme_setting_i(scheme_set),
        .start_lockout_setting_i(lock_set), .reference_loss_setting_i(loss_set), .command_source_i(source),
        .other_run_i(other_run), .other_fwd_i(other_fwd), .mode_key_i(mode_key), .run_o(run), .fwd_o(forward_run_input),
        .rev_o(reverse_run_input), .ramp_to_zero_o(ramp), .coast_stop_o(coast), .hold_freq_o(hold),
        .external_fault_indication_o(fault), .analog_loss_warning_o(warn), .stop_key_enable_o(stop_key));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic do_reset(input logic f);
        @(negedge clk_i);
        rst_n_i = 1'b0;
        fwd_req = f;
        rev_req = 1'b0;
        other_run = 1'b0;
        idle(2);
        rst_n_i = 1'b1;
        idle(6);
    endtask
    task automatic pins(input logic f, input logic r);
        fwd_req = f;
        rev_req = r;
        idle(5);
    endtask
    task automatic mot(input logic [2:0] exp);
        chk({1'b0, run, forward_run_input, reverse_run_input}, {1'b0, exp}, "motion");
    endtask
    // ------------------------------------------------------------
    // Cycle ceiling
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        mot(3'b000);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        mot(3'b110);
        lock_set = 2'h0;
        do_reset(1'b1);
        mot(3'b110);
        en_i = 1'b0;
        pins(1'b0, 1'b1);
        mot(3'b110);
        en_i = 1'b1;
        pins(1'b0, 1'b1);
        mot(3'b101);
        pins(1'b1, 1'b1);
        mot(3'b000);
        dir_set = 2'h1;
        pins(1'b0, 1'b1);
        mot(3'b000);
        pins(1'b1, 1'b0);
        mot(3'b110);
        dir_set = 2'h2;
        idle(5);
        mot(3'b000);
        dir_set = 2'h0;
        scheme_set = 2'h1;
        pins(1'b1, 1'b1);
        mot(3'b101);
        pins(1'b1, 1'b0);
        mot(3'b110);
        pins(1'b0, 1'b0);
        mot(3'b000);
        scheme_set = 2'h2;
        pins(1'b1, 1'b1);
        pins(1'b0, 1'b1);
        mot(3'b101);
        stop_req = 1'b0;
        idle(5);
        mot(3'b000);
        stop_req = 1'b1;
        idle(5);
        mot(3'b000);
        scheme_set = 2'h0;
        for (int l = 0; l < 4; l++) begin
            lock_set = l[1:0];
            source = 3'h0;
            do_reset(1'b0);
            other_run = 1'b1;
            idle(5);
            mot(3'b110);
            source = 3'h1;
            idle(5);
            mot(l[1] ? 3'b000 : 3'b110);
        end
        other_run = 1'b0;
        for (int s = 0; s < 3; s++) begin
            loss_set = s[1:0];
            pins(1'b0, 1'b0);
            pins(1'b1, 1'b0);
            lost_req = 1'b1;
            idle(5);
            chk({ramp, coast, hold, warn}, (s == 0) ? 4'h9 : (s == 1) ? 4'h4 : 4'h3, "loss");
            lost_req = 1'b0;
            idle(5);
            chk({3'h0, warn}, 4'h0, "warn");
            chk({3'h0, fault}, {3'h0, s == 1}, "fault");
            mode_key = 1'b1;
            idle(1);
            mode_key = 1'b0;
            idle(2);
            chk({3'h0, fault}, 4'h0, "fault");
        end
        for (int src = 0; src < 5; src++) begin
            source = src[2:0];
            idle(1);
            chk({3'h0, stop_key}, {3'h0, src != 2 && src != 4}, "stop key");
        end
        tally_and_finish();
    end
endmodule // drc_run_command_tb_top
